// >>> gpb_gpio.sv
// Function
// - port J direction register, one is output
// - port K data register at 0x90
// - port K direction register, one is output
// - eight bypass muxes onto target pins
// - select bit n pairs group G/H pin n
// - bypass select register at 0x7F85, reset zero
// - select zero: both pins plain GPIO
// - select one: target driven by source level
// - select register writable only by microcontroller
// - bypass forces target output driver on
// - normal mode: target direction from own bit
// - bypassed target input bit hides pin level
// - source pins keep feeding interrupts and wake
// - one address: read latch on output bits and pins on input bits, write latch
// - port J at 0x80, bit set/clear access
`timescale 1ns/1ps
`default_nettype none
module gpb_gpio
  import gpb_pkg::*;
(
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST_B,
  // special-function byte access
  input  wire logic [7:0]  I_SFR_ADDR,
  input  wire logic        I_SFR_WR,
  input  wire logic        I_SFR_RD,
  input  wire logic [7:0]  I_SFR_WDATA,
  output logic      [7:0]  O_SFR_RDATA,
  // special-function single-bit set/clear
  input  wire logic [7:0]  I_SFR_BIT_ADDR,
  input  wire logic        I_SFR_BIT_WR,
  input  wire logic        I_SFR_BIT_VAL,
  // memory-mapped control register access
  input  wire logic [15:0] I_MM_ADDR,
  input  wire logic        I_MM_WR,
  input  wire logic        I_MM_RD,
  input  wire logic [7:0]  I_MM_WDATA,
  output logic      [7:0]  O_MM_RDATA,
  // port J pins
  input  wire logic [7:0]  I_PJ_PIN,
  output logic      [7:0]  O_PJ_OUT,
  output logic      [7:0]  O_PJ_OE,
  // port K pins
  input  wire logic [7:0]  I_PK_PIN,
  output logic      [7:0]  O_PK_OUT,
  output logic      [7:0]  O_PK_OE,
  // group G source pins and their status toward the controller
  input  wire logic [7:0]  I_GG_PIN,
  output logic      [7:0]  O_GG_IN,
  // group H target pins, own GPIO logic and pin side
  input  wire logic [7:0]  I_GH_GPIO_OUT,
  input  wire logic [7:0]  I_GH_GPIO_DIR,
  input  wire logic [7:0]  I_GH_PIN,
  output logic      [7:0]  O_GH_IN,
  output logic      [7:0]  O_GH_OUT,
  output logic      [7:0]  O_GH_OE
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // byte view of a port: latch on outputs, pin on inputs
  function automatic logic [7:0] port_view(input logic [7:0] latch,
                                           input logic [7:0] dir,
                                           input logic [7:0] pin);
    port_view = (latch & dir) | (pin & ~dir);
  endfunction

  // single-bit set or clear of one latch bit
  function automatic logic [7:0] bit_upd(input logic [7:0] cur,
                                         input logic [2:0] idx,
                                         input logic       val);
    logic [7:0] tmp;
    tmp      = cur;
    tmp[idx] = val;
    bit_upd  = tmp;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic [1:0] rst_sync_q;   // release shifter
  logic       rst_n;        // synchronised reset, active low

  // assert at once, release after two edges
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  logic [7:0] pj_m_q, pj_s_q; // port J pin sync
  logic [7:0] pk_m_q, pk_s_q; // port K pin sync
  logic [7:0] gg_m_q, gg_s_q; // group G pin sync
  logic [7:0] gh_m_q, gh_s_q; // group H pin sync

  // pins are asynchronous: two stages before any use
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pj_m_q <= 8'h00;
      pj_s_q <= 8'h00;
      pk_m_q <= 8'h00;
      pk_s_q <= 8'h00;
      gg_m_q <= 8'h00;
      gg_s_q <= 8'h00;
      gh_m_q <= 8'h00;
      gh_s_q <= 8'h00;
    end else begin
      pj_m_q <= I_PJ_PIN;
      pj_s_q <= pj_m_q;
      pk_m_q <= I_PK_PIN;
      pk_s_q <= pk_m_q;
      gg_m_q <= I_GG_PIN;
      gg_s_q <= gg_m_q;
      gh_m_q <= I_GH_PIN;
      gh_s_q <= gh_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode

  logic sfr_wr_j, sfr_wr_k, bit_wr_j, bit_wr_k;
  logic mm_wr_sel, mm_wr_dj, mm_wr_dk;

  assign sfr_wr_j  = I_SFR_WR && (I_SFR_ADDR == SFR_PORT_J);
  assign sfr_wr_k  = I_SFR_WR && (I_SFR_ADDR == SFR_PORT_K);
  // bit address = port base + bit number
  assign bit_wr_j  = I_SFR_BIT_WR &&
                     (I_SFR_BIT_ADDR[7:BIT_NUM_W] ==
                      SFR_PORT_J[7:BIT_NUM_W]);
  assign bit_wr_k  = I_SFR_BIT_WR &&
                     (I_SFR_BIT_ADDR[7:BIT_NUM_W] ==
                      SFR_PORT_K[7:BIT_NUM_W]);
  // only the controller's own bus reaches these; no host path exists
  assign mm_wr_sel = I_MM_WR && (I_MM_ADDR == MM_BYPASS_SEL);
  assign mm_wr_dj  = I_MM_WR && (I_MM_ADDR == MM_PORT_J_DIR);
  assign mm_wr_dk  = I_MM_WR && (I_MM_ADDR == MM_PORT_K_DIR);

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] pj_lat_q, pk_lat_q; // output latches
  logic [7:0] pj_dir_q, pk_dir_q; // direction, one is output
  logic [7:0] sel_q;              // bypass select, bit n-1 = pair n

  // port latches; byte write wins over a same-cycle bit write
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pj_lat_q <= RST_DATA;
      pk_lat_q <= RST_DATA;
    end else begin
      if (sfr_wr_j) begin
        pj_lat_q <= I_SFR_WDATA;
      end else if (bit_wr_j) begin
        pj_lat_q <= bit_upd(pj_lat_q, I_SFR_BIT_ADDR[2:0],
                            I_SFR_BIT_VAL);
      end
      if (sfr_wr_k) begin
        pk_lat_q <= I_SFR_WDATA;
      end else if (bit_wr_k) begin
        pk_lat_q <= bit_upd(pk_lat_q, I_SFR_BIT_ADDR[2:0],
                            I_SFR_BIT_VAL);
      end
    end
  end

  // direction and select; nothing else ever touches them
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pj_dir_q <= RST_DIR;
      pk_dir_q <= RST_DIR;
      sel_q    <= RST_SEL;
    end else begin
      if (mm_wr_dj) begin
        pj_dir_q <= I_MM_WDATA;
      end
      if (mm_wr_dk) begin
        pk_dir_q <= I_MM_WDATA;
      end
      if (mm_wr_sel) begin
        sel_q <= I_MM_WDATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, registered one cycle after the strobe

  // special-function reads
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_SFR_RDATA <= UNMAPPED_VAL;
    end else if (I_SFR_RD) begin
      case (I_SFR_ADDR)
        SFR_PORT_J: O_SFR_RDATA <= port_view(pj_lat_q, pj_dir_q, pj_s_q);
        SFR_PORT_K: O_SFR_RDATA <= port_view(pk_lat_q, pk_dir_q, pk_s_q);
        default:    O_SFR_RDATA <= UNMAPPED_VAL;
      endcase
    end
  end

  // memory-mapped reads
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_MM_RDATA <= UNMAPPED_VAL;
    end else if (I_MM_RD) begin
      case (I_MM_ADDR)
        MM_BYPASS_SEL: O_MM_RDATA <= sel_q;
        MM_PORT_J_DIR: O_MM_RDATA <= pj_dir_q;
        MM_PORT_K_DIR: O_MM_RDATA <= pk_dir_q;
        default:       O_MM_RDATA <= UNMAPPED_VAL;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port pin drive: straight from latch and direction flops

  assign O_PJ_OUT = pj_lat_q;
  assign O_PJ_OE  = pj_dir_q;
  assign O_PK_OUT = pk_lat_q;
  assign O_PK_OE  = pk_dir_q;

  ////////////////////////////////////////////////////////////////////////
  // bypass muxes; the source level costs the sync plus one flop,
  // so the copy on the target lags the source pin by three clocks

  // target drive and status per pair
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_GH_OUT <= 8'h00;
      O_GH_OE  <= 8'h00;
      O_GH_IN  <= MASKED_IN;
      O_GG_IN  <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (sel_q[i]) begin
          O_GH_OUT[i] <= gg_s_q[i];
          O_GH_OE[i]  <= 1'b1;
          O_GH_IN[i]  <= MASKED_IN[i];
        end else begin
          // back to own logic, registers untouched
          O_GH_OUT[i] <= I_GH_GPIO_OUT[i];
          O_GH_OE[i]  <= I_GH_GPIO_DIR[i];
          O_GH_IN[i]  <= gh_s_q[i];
        end
      end
      // source status goes on to interrupt and wake logic
      O_GG_IN <= gg_s_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!rst_n);

  // a select write followed by an idle cycle, so nothing overwrites it
  sequence s_sel_written;
    mm_wr_sel ##1 !mm_wr_sel;
  endsequence

  // a pure read of the select register
  sequence s_sel_read;
    I_MM_RD && !I_MM_WR && I_MM_ADDR == MM_BYPASS_SEL;
  endsequence

  a_dirj_write: assert property (mm_wr_dj |=>
      O_PJ_OE == $past(I_MM_WDATA))
    else $error("port J direction not loaded");
  a_portk_byte: assert property (sfr_wr_k |=>
      O_PK_OUT == $past(I_SFR_WDATA))
    else $error("port K latch not loaded");
  a_dirk_write: assert property (mm_wr_dk |=>
      O_PK_OE == $past(I_MM_WDATA))
    else $error("port K direction not loaded");
  a_sel_readback: assert property (s_sel_written ##1 s_sel_read |=>
      O_MM_RDATA == $past(I_MM_WDATA, 3))
    else $error("select readback wrong");
  a_bypass_data: assert property (sel_q[0] && $stable(sel_q)
      |=> O_GH_OUT[0] == $past(gg_s_q[0]) && O_GH_OE[0])
    else $error("bypass pair 1 not copying source");
  a_bypass_top: assert property (sel_q[7]
      |=> O_GH_OE[7] && O_GH_IN[7] == MASKED_IN[7])
    else $error("bypass pair 8 drive or mask wrong");
  a_normal_dir: assert property (!sel_q[3]
      |=> O_GH_OE[3] == $past(I_GH_GPIO_DIR[3]) &&
          O_GH_OUT[3] == $past(I_GH_GPIO_OUT[3]))
    else $error("normal mode target not from own logic");
  a_source_in: assert property (1'b1 |=> O_GG_IN == $past(gg_s_q))
    else $error("source status altered");
  a_bitset_j: assert property (bit_wr_j && !sfr_wr_j |=>
      O_PJ_OUT[$past(I_SFR_BIT_ADDR[2:0])] == $past(I_SFR_BIT_VAL))
    else $error("port J bit access failed");
  a_sel_keeps: assert property (mm_wr_sel |=>
      $stable(pj_lat_q) || $past(sfr_wr_j || bit_wr_j))
    else $error("mode change altered a latch");

endmodule
`default_nettype wire

// >>> gpb_pkg.sv
package gpb_pkg;
  // special-function addresses of the two data ports
  localparam logic [7:0]  SFR_PORT_J      = 8'h80; // port J data
  localparam logic [7:0]  SFR_PORT_K      = 8'h90; // port K data
  // bit address field split: base in [7:3], bit number in [2:0]
  localparam int          BIT_NUM_W       = 3;
  // memory-mapped control register addresses
  localparam logic [15:0] MM_BYPASS_SEL   = 16'h7F85; // bypass select
  localparam logic [15:0] MM_PORT_J_DIR   = 16'h7FAD; // port J direction
  localparam logic [15:0] MM_PORT_K_DIR   = 16'h7FAE; // port K direction
  // reset values
  localparam logic [7:0]  RST_DATA        = 8'h00; // output latches
  localparam logic [7:0]  RST_DIR         = 8'h00; // all inputs
  localparam logic [7:0]  RST_SEL         = 8'h00; // bypass off
  localparam logic [7:0]  UNMAPPED_VAL    = 8'h00; // unmapped read
  localparam logic [7:0]  MASKED_IN       = 8'h00; // bypassed target
endpackage

// >>> gpb_board_model.sv
`timescale 1ns/1ps
`default_nettype none
// board side of one 8-bit pin group: where the chip drives, the pad
// follows the chip; elsewhere the board's own level shows
module gpb_board_model (
  // chip side
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  // board side
  input  wire logic [7:0] i_drv,
  output logic      [7:0] o_pin
);
  // no contention modelled: the chip always wins its driven bits
  assign o_pin = (i_out & i_oe) | (i_drv & ~i_oe);
endmodule
`default_nettype wire

// >>> gpb_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  error_cnt++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module testbench;
  import gpb_pkg::*;
  logic        clk, rst_b, swr, srd, bwr, bv, mwr, mrd;
  logic [7:0]  sa, swd, s_rd, ba, mwd, m_rd;
  logic [15:0] ma;
  logic [7:0]  pj, pjo, pjoe, pk, pko, pkoe, gg, gg_in;
  logic [7:0]  go, gd, gh, gh_in, gh_out, gh_oe;
  logic [7:0]  dj, dk, dg, dh; // board drive levels
  int          error_cnt, comparisons;
  //////////////////////////////////////////////////////////////////////
  always #20 clk = ~clk;
  gpb_gpio DUT (
    .I_CLK(clk), .I_RST_B(rst_b), .I_SFR_ADDR(sa), .I_SFR_WR(swr),
    .I_SFR_RD(srd), .I_SFR_WDATA(swd), .O_SFR_RDATA(s_rd),
    .I_SFR_BIT_ADDR(ba), .I_SFR_BIT_WR(bwr), .I_SFR_BIT_VAL(bv),
    .I_MM_ADDR(ma), .I_MM_WR(mwr), .I_MM_RD(mrd), .I_MM_WDATA(mwd),
    .O_MM_RDATA(m_rd), .I_PJ_PIN(pj), .O_PJ_OUT(pjo), .O_PJ_OE(pjoe),
    .I_PK_PIN(pk), .O_PK_OUT(pko), .O_PK_OE(pkoe), .I_GG_PIN(gg),
    .O_GG_IN(gg_in), .I_GH_GPIO_OUT(go), .I_GH_GPIO_DIR(gd),
    .I_GH_PIN(gh), .O_GH_IN(gh_in), .O_GH_OUT(gh_out), .O_GH_OE(gh_oe));
  // board around each pin group; group G is never driven by the chip
  gpb_board_model BJ (.i_out(pjo), .i_oe(pjoe), .i_drv(dj), .o_pin(pj));
  gpb_board_model BK (.i_out(pko), .i_oe(pkoe), .i_drv(dk), .o_pin(pk));
  gpb_board_model BG (.i_out(8'h00), .i_oe(8'h00), .i_drv(dg),
    .o_pin(gg));
  gpb_board_model BH (.i_out(gh_out), .i_oe(gh_oe), .i_drv(dh),
    .o_pin(gh));
  //////////////////////////////////////////////////////////////////////
  // one-cycle strobes; strobe drops at the edge that takes it
  task automatic mw(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk); ma <= a; mwd <= d; mwr <= 1'b1;
    @(posedge clk); mwr <= 1'b0;
  endtask
  task automatic mr(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk); ma <= a; mrd <= 1'b1;
    @(posedge clk); mrd <= 1'b0;
    #1 `CHK(m_rd, e)
  endtask
  task automatic sw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); sa <= a; swd <= d; swr <= 1'b1;
    @(posedge clk); swr <= 1'b0;
  endtask
  task automatic sr(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk); sa <= a; srd <= 1'b1;
    @(posedge clk); srd <= 1'b0;
    #1 `CHK(s_rd, e)
  endtask
  task automatic bw(input logic [7:0] a, input logic v);
    @(posedge clk); ba <= a; bv <= v; bwr <= 1'b1;
    @(posedge clk); bwr <= 1'b0;
  endtask
  // target pins under select s; pins settle within the 2-flop sync plus output flop;
  // second pass with the source inverted so every bypassed bit moves
  task automatic chk_gh(input logic [7:0] s);
    logic [7:0] pin;
    repeat (2) begin
      repeat (4) @(posedge clk);
      #1 pin = (go & gd) | (dh & ~gd);
      `CHK(gh_oe, gd | s)
      `CHK(gh_out, (dg & s) | (go & ~s))
      `CHK(gh_in, pin & ~s)
      `CHK(gg_in, dg)
      @(posedge clk);
      dg <= ~dg;
    end
  endtask
  task automatic close_out;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // watchdog: the whole run needs far fewer cycles
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  initial begin
    {clk, rst_b, swr, srd, bwr, bv, mwr, mrd} = '0;
    {sa, swd, ba, mwd, ma} = '0;
    {go, gd, dj, dk, dg, dh} = {8'h0F, 8'h33, 8'h3C, 8'h5A, 8'hA6, 8'h55};
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    mr(MM_PORT_J_DIR, RST_DIR);
    mr(MM_PORT_K_DIR, RST_DIR);
    mr(MM_BYPASS_SEL, RST_SEL);
    `CHK(pko, RST_DATA)
    // port J: mixed directions, read merges latch and pins
    mw(MM_PORT_J_DIR, 8'hF0);
    sw(SFR_PORT_J, 8'hA5);
    repeat (3) @(posedge clk);
    sr(SFR_PORT_J, 8'hAC);
    `CHK(pjoe, 8'hF0)
    // port J single-bit set and clear on the output latch
    bw(SFR_PORT_J + 8'h01, 1'b1);
    bw(SFR_PORT_J + 8'h07, 1'b0);
    repeat (2) @(posedge clk);
    `CHK(pjo, 8'h27)
    sr(SFR_PORT_J, 8'h2C);
    // port K: single-bit set and clear, then all outputs
    bw(SFR_PORT_K + 8'h07, 1'b1);
    bw(SFR_PORT_K + 8'h01, 1'b1);
    bw(SFR_PORT_K + 8'h03, 1'b1);
    bw(SFR_PORT_K + 8'h03, 1'b0);
    repeat (2) @(posedge clk);
    `CHK(pko, 8'h82)
    sr(SFR_PORT_K, 8'h5A);
    mw(MM_PORT_K_DIR, 8'hFF);
    mr(MM_PORT_K_DIR, 8'hFF);
    sr(SFR_PORT_K, 8'h82);
    `CHK(pkoe, 8'hFF)
    // unmapped places read as zero
    mr(16'h7F86, UNMAPPED_VAL);
    sr(8'hA0, UNMAPPED_VAL);
    // bypass: each pair alone, then all, then back to normal
    chk_gh(8'h00);
    for (int i = 0; i < 8; i++) begin
      mw(MM_BYPASS_SEL, 8'h01 << i);
      mr(MM_BYPASS_SEL, 8'h01 << i);
      chk_gh(8'h01 << i);
    end
    mw(MM_BYPASS_SEL, 8'hFF);
    gd <= 8'hCC;
    chk_gh(8'hFF);
    mw(MM_BYPASS_SEL, 8'h00);
    chk_gh(8'h00);
    mr(MM_PORT_K_DIR, 8'hFF);
    `CHK(pko, 8'h82)
    close_out();
  end
endmodule
`default_nettype wire
